//--- design/ebw_defs.vh
// Register map, field positions, reset values and cycle step codes for the external bus unit
`ifndef EBW_DEFS_VH
`define EBW_DEFS_VH
`define EBW_ADDR_W 8
`define EBW_REG_UPPER_CTL 8'h00
`define EBW_REG_LOWER_CTL 8'h04
`define EBW_REG_AUX_CFG 8'h08
`define EBW_REG_XADDR 8'h0c
`define EBW_REG_XWDATA 8'h10
`define EBW_REG_CMD 8'h14
`define EBW_REG_XRDATA 8'h18
`define EBW_REG_PIO 8'h1c
`define EBW_BIT_DISABLE 0
`define EBW_BIT_LOWER_W 0
`define EBW_BIT_IO_W 1
`define EBW_BIT_OTHER_W 2
`define EBW_BIT_CMD_WRITE 0
`define EBW_BIT_CMD_WORD 1
`define EBW_BIT_CMD_SPACE 2
`define EBW_BIT_ST_BUSY 0
`define EBW_BIT_ST_STRAP 1
`define EBW_BIT_ST_HOLD 2
`define EBW_RST_AUX 3'h0
`define EBW_RST_PIO 4'h0
`define EBW_SPACE_UPPER 2'h0
`define EBW_SPACE_LOWER 2'h1
`define EBW_SPACE_IO 2'h2
`define EBW_SPACE_OTHER 2'h3
`define EBW_STEP_PRE 4'h0
`define EBW_STEP_T1_END 4'h2
`define EBW_STEP_T2 4'h3
`define EBW_STEP_SAMPLE 4'h6
`define EBW_STEP_T4_END 4'h8
`define EBW_STEP_IDLE 4'h9
`endif

//--- design/ebw_strap_capture.v
// Captures the address-enable strap one clock after reset is released
`timescale 1ns/1ps
module ebw_strap_capture (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Strap pin and captured level
  input wire address_enable_strap,
  output reg strap_low_q
);
  reg taken_q;

  // The strap is sampled only once after each reset, so later pin activity cannot change the mode
  always @(posedge clk) begin
    if (rst) begin
      taken_q <= 1'b0;
      strap_low_q <= 1'b0;
    end else if (!taken_q) begin
      taken_q <= 1'b1;
      strap_low_q <= ~address_enable_strap;
    end
  end
endmodule

//--- design/ebw_write_enables.v
// Byte write enable and write strobe pins with their three-state control
`timescale 1ns/1ps
module ebw_write_enables (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Next-cycle sources
  input wire narrow,
  input wire hold,
  input wire bus_high_enable_n_d,
  input wire addr0_d,
  input wire write_strobe_n_d,
  // Pins
  output reg write_high_byte_n,
  output reg write_high_byte_oe_n,
  output reg write_low_byte_n,
  output reg write_low_byte_oe_n,
  output reg write_byte_n,
  output reg write_byte_oe_n,
  output reg write_strobe_n,
  output reg write_strobe_oe_n
);
  wire whb_d;
  wire wlb_d;

  assign whb_d = bus_high_enable_n_d | write_strobe_n_d;
  assign wlb_d = addr0_d | write_strobe_n_d;

  // Registered on the same edge as the non-multiplexed address so both line up at the SRAM
  always @(posedge clk) begin
    if (rst) begin
      write_high_byte_n <= 1'b1;
      write_low_byte_n <= 1'b1;
      write_byte_n <= 1'b1;
      write_strobe_n <= 1'b1;
      write_high_byte_oe_n <= 1'b1;
      write_low_byte_oe_n <= 1'b1;
      write_byte_oe_n <= 1'b1;
      write_strobe_oe_n <= 1'b1;
    end else begin
      write_high_byte_n <= whb_d;
      write_low_byte_n <= wlb_d;
      write_byte_n <= whb_d & wlb_d;
      write_strobe_n <= write_strobe_n_d;
      write_high_byte_oe_n <= narrow;
      write_low_byte_oe_n <= narrow;
      write_byte_oe_n <= ~narrow;
      write_strobe_oe_n <= hold;
    end
  end
endmodule

//--- design/ebw_bus_unit.v
// External bus unit: cycle sequencer, address/data pins, bus sizing and register slave
//
// Notes on behaviour
// - high-byte enable is bus-high-enable OR strobe
// - low-byte enable is address bit0 OR strobe
// - narrow variant combines both enables by AND
// - byte enables map lanes; float in reset
// - combined enable early, floats in reset
// - write strobe floats in hold and reset
// - byte enables aligned with non-multiplexed address
// - shared bus carries address only in t1
// - non-multiplexed address valid t1 through t4
// - non-multiplexed address half clock earlier
// - disable bit floats shared bus address phase
// - narrow variant drives upper lines in data
// - strap low ignores both disable bits
// - strap low enables status pins' normal use
// - width fields pick 16 or 8 bits
// - narrow variant uses 8 bits everywhere
// - strap sampled one clock after reset
`timescale 1ns/1ps
`include "ebw_defs.vh"
module ebw_bus_unit #(
  parameter NARROW = 0
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Bus hold
  input wire hold_request,
  output reg hold_ack,
  // Strap
  input wire address_enable_strap,
  // Clock out and address buses
  output reg processor_clock_out,
  output reg [19:0] nonmux_address,
  output reg nonmux_address_oe_n,
  output reg [15:0] ad_out,
  output reg [15:0] ad_oe_n,
  input wire [15:0] ad_in,
  output reg [7:0] upper_address_only_lines,
  output reg upper_address_only_oe_n,
  // Selects and status
  output reg upper_memory_select_n,
  output reg lower_memory_select_n,
  output reg bus_high_enable_n,
  output reg cycle_status_6,
  output reg cycle_status_6_oe_n,
  output reg upper_zero_indicate,
  output reg upper_zero_indicate_oe_n,
  // Write enables
  output wire write_high_byte_n,
  output wire write_high_byte_oe_n,
  output wire write_low_byte_n,
  output wire write_low_byte_oe_n,
  output wire write_byte_n,
  output wire write_byte_oe_n,
  output wire write_strobe_n,
  output wire write_strobe_oe_n
);
  localparam NARROW_B = (NARROW != 0) ? 1'b1 : 1'b0;

  reg upper_disable_q;
  reg lower_disable_q;
  reg [2:0] aux_q;
  reg [19:0] xaddr_q;
  reg [15:0] xwdata_q;
  reg [15:0] xrdata_q;
  reg [3:0] pio_q;
  reg cmd_write_q;
  reg cmd_word_q;
  reg [1:0] cmd_space_q;
  reg split_q;
  reg busy_q;
  reg pend_q;
  reg beat_q;
  reg [3:0] step_q;
  reg ph_q;
  reg busy_d;
  reg pend_d;
  reg beat_d;
  reg [3:0] step_d;
  wire strap_low;
  wire start;
  wire wb_req;
  wire wb_wr;
  wire idle;
  wire narrow_sp;
  wire dis_addr;
  wire [19:0] cur_addr;
  wire [19:0] now_addr;
  wire in_t1;
  wire in_data;
  wire in_cyc;
  wire whole_word;
  wire [7:0] beat_byte;
  wire [7:0] rd_lane;
  wire bhe_n_d;
  wire a0_d;
  wire wr_n_d;
  reg [31:0] rd_mux;

  // Byte-lane merge of a Wishbone write into a register image
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  // An address space runs 8 bits wide on the narrow variant or when its field is set
  function is_narrow;
    input [1:0] space;
    input [2:0] aux;
    begin
      case (space)
        `EBW_SPACE_UPPER: is_narrow = NARROW_B;
        `EBW_SPACE_LOWER: is_narrow = NARROW_B | aux[`EBW_BIT_LOWER_W];
        `EBW_SPACE_IO: is_narrow = NARROW_B | aux[`EBW_BIT_IO_W];
        default: is_narrow = NARROW_B | aux[`EBW_BIT_OTHER_W];
      endcase
    end
  endfunction

  ebw_strap_capture u_strap (
    .clk(clk),
    .rst(rst),
    .address_enable_strap(address_enable_strap),
    .strap_low_q(strap_low)
  );

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o;
  assign idle = ~busy_q & ~pend_q;
  assign start = pend_q & ph_q & ~hold_ack;
  wire hold_d = hold_request & ~busy_d & ~pend_d;
  wire [31:0] xaddr_m = merge({12'h000, xaddr_q}, wb_dat_i, wb_sel_i);
  wire [31:0] xwdata_m = merge({16'h0000, xwdata_q}, wb_dat_i, wb_sel_i);

  // Cycle sequencer: step 0 is the half clock before t1, steps 1..8 are t1..t4, 9 is idle
  always @* begin
    busy_d = busy_q;
    pend_d = pend_q;
    beat_d = beat_q;
    step_d = step_q;
    if (wb_wr && wb_adr_i == `EBW_REG_CMD && idle && wb_sel_i[0]) begin
      pend_d = 1'b1;
    end else if (start) begin
      pend_d = 1'b0;
      busy_d = 1'b1;
      beat_d = 1'b0;
      step_d = `EBW_STEP_PRE;
    end else if (busy_q) begin
      if (step_q == `EBW_STEP_IDLE) begin
        if (split_q && !beat_q) begin
          beat_d = 1'b1;
          step_d = `EBW_STEP_PRE;
        end else begin
          busy_d = 1'b0;
        end
      end else begin
        step_d = step_q + 4'h1;
      end
    end
  end

  assign narrow_sp = is_narrow(cmd_space_q, aux_q);
  // Strap low keeps the classic multiplexed bus whatever the disable bits say
  assign dis_addr = ~strap_low &
    ((cmd_space_q == `EBW_SPACE_UPPER & upper_disable_q) |
     (cmd_space_q == `EBW_SPACE_LOWER & lower_disable_q));
  assign cur_addr = xaddr_q + {19'h00000, beat_d};
  assign now_addr = xaddr_q + {19'h00000, beat_q};
  assign in_cyc = busy_d & (step_d != `EBW_STEP_IDLE);
  assign in_t1 = in_cyc & (step_d != `EBW_STEP_PRE) & (step_d <= `EBW_STEP_T1_END);
  assign in_data = in_cyc & (step_d >= `EBW_STEP_T2) & (step_d <= `EBW_STEP_T4_END);
  assign whole_word = cmd_word_q & ~split_q;
  assign beat_byte = (cmd_word_q & beat_d) ? xwdata_q[15:8] : xwdata_q[7:0];
  assign rd_lane = (!narrow_sp && now_addr[0]) ? ad_in[15:8] : ad_in[7:0];

  // Lane selection; a narrow space always uses the low lane
  assign bhe_n_d = ~in_cyc | narrow_sp | (~whole_word & ~cur_addr[0]);
  assign a0_d = ~in_cyc | (~narrow_sp & cur_addr[0]);
  assign wr_n_d = ~(in_cyc & cmd_write_q & (step_d >= `EBW_STEP_T2) &
    (step_d <= `EBW_STEP_SAMPLE));

  ebw_write_enables u_we (
    .clk(clk),
    .rst(rst),
    .narrow(NARROW_B),
    .hold(hold_d),
    .bus_high_enable_n_d(bhe_n_d),
    .addr0_d(a0_d),
    .write_strobe_n_d(wr_n_d),
    .write_high_byte_n(write_high_byte_n),
    .write_high_byte_oe_n(write_high_byte_oe_n),
    .write_low_byte_n(write_low_byte_n),
    .write_low_byte_oe_n(write_low_byte_oe_n),
    .write_byte_n(write_byte_n),
    .write_byte_oe_n(write_byte_oe_n),
    .write_strobe_n(write_strobe_n),
    .write_strobe_oe_n(write_strobe_oe_n)
  );

  always @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      beat_q <= 1'b0;
      step_q <= `EBW_STEP_IDLE;
      ph_q <= 1'b0;
      hold_ack <= 1'b0;
    end else begin
      busy_q <= busy_d;
      pend_q <= pend_d;
      beat_q <= beat_d;
      step_q <= step_d;
      ph_q <= ~ph_q;
      hold_ack <= hold_d;
    end
  end

  // Pins are registered from the next step so every pin changes on one common edge
  always @(posedge clk) begin
    if (rst) begin
      processor_clock_out <= 1'b0;
      nonmux_address <= 20'h00000;
      nonmux_address_oe_n <= 1'b1;
      ad_out <= 16'h0000;
      ad_oe_n <= 16'hffff;
      upper_address_only_lines <= 8'h00;
      upper_address_only_oe_n <= 1'b1;
      upper_memory_select_n <= 1'b1;
      lower_memory_select_n <= 1'b1;
      bus_high_enable_n <= 1'b1;
      cycle_status_6 <= 1'b0;
      cycle_status_6_oe_n <= 1'b1;
      upper_zero_indicate <= 1'b1;
      upper_zero_indicate_oe_n <= 1'b1;
    end else begin
      processor_clock_out <= ~ph_q;
      nonmux_address_oe_n <= hold_d;
      if (in_cyc) begin
        nonmux_address <= cur_addr;
      end
      bus_high_enable_n <= bhe_n_d;
      upper_memory_select_n <= ~(in_t1 | in_data) | (cmd_space_q != `EBW_SPACE_UPPER);
      lower_memory_select_n <= ~(in_t1 | in_data) | (cmd_space_q != `EBW_SPACE_LOWER);
      if (in_t1 && !dis_addr) begin
        ad_out <= cur_addr[15:0];
        ad_oe_n <= NARROW_B ? 16'hff00 : 16'h0000;
      end else if (in_data && cmd_write_q) begin
        ad_out <= whole_word ? xwdata_q : {beat_byte, beat_byte};
        ad_oe_n <= NARROW_B ? 16'hff00 : 16'h0000;
      end else begin
        ad_oe_n <= 16'hffff;
      end
      upper_address_only_lines <= cur_addr[15:8];
      upper_address_only_oe_n <= ~(NARROW_B & ((in_t1 & ~dis_addr) | in_data));
      if (strap_low) begin
        cycle_status_6 <= 1'b0;
        cycle_status_6_oe_n <= hold_ack;
        upper_zero_indicate <= ~((in_t1 | in_data) & (cur_addr[19:16] == 4'h0));
        upper_zero_indicate_oe_n <= 1'b0;
      end else begin
        cycle_status_6 <= pio_q[0];
        cycle_status_6_oe_n <= ~pio_q[2];
        upper_zero_indicate <= pio_q[1];
        upper_zero_indicate_oe_n <= ~pio_q[3];
      end
    end
  end

  // Read data is taken at the end of t3
  always @(posedge clk) begin
    if (rst) begin
      xrdata_q <= 16'h0000;
    end else if (busy_q && !cmd_write_q && step_q == `EBW_STEP_SAMPLE) begin
      if (!cmd_word_q) begin
        xrdata_q <= {8'h00, rd_lane};
      end else if (!split_q) begin
        xrdata_q <= ad_in;
      end else if (!beat_q) begin
        xrdata_q[7:0] <= rd_lane;
      end else begin
        xrdata_q[15:8] <= rd_lane;
      end
    end
  end

  always @* begin
    case (wb_adr_i)
      `EBW_REG_UPPER_CTL: rd_mux = {31'h00000000, upper_disable_q};
      `EBW_REG_LOWER_CTL: rd_mux = {31'h00000000, lower_disable_q};
      `EBW_REG_AUX_CFG: rd_mux = {29'h00000000, aux_q};
      `EBW_REG_XADDR: rd_mux = {12'h000, xaddr_q};
      `EBW_REG_XWDATA: rd_mux = {16'h0000, xwdata_q};
      `EBW_REG_CMD: rd_mux = {29'h00000000, hold_ack, strap_low, ~idle};
      `EBW_REG_XRDATA: rd_mux = {16'h0000, xrdata_q};
      `EBW_REG_PIO: rd_mux = {28'h0000000, pio_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Registers; address and command are refused while an access is queued or running
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      upper_disable_q <= 1'b0;
      lower_disable_q <= 1'b0;
      aux_q <= `EBW_RST_AUX;
      pio_q <= `EBW_RST_PIO;
      xaddr_q <= 20'h00000;
      xwdata_q <= 16'h0000;
      cmd_write_q <= 1'b0;
      cmd_word_q <= 1'b0;
      cmd_space_q <= `EBW_SPACE_UPPER;
      split_q <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
      if (wb_wr) begin
        case (wb_adr_i)
          `EBW_REG_UPPER_CTL: upper_disable_q <= wb_sel_i[0] ? wb_dat_i[`EBW_BIT_DISABLE] :
            upper_disable_q;
          `EBW_REG_LOWER_CTL: lower_disable_q <= wb_sel_i[0] ? wb_dat_i[`EBW_BIT_DISABLE] :
            lower_disable_q;
          `EBW_REG_AUX_CFG: aux_q <= wb_sel_i[0] ? wb_dat_i[2:0] : aux_q;
          `EBW_REG_PIO: pio_q <= wb_sel_i[0] ? wb_dat_i[3:0] : pio_q;
          `EBW_REG_XADDR: xaddr_q <= idle ? xaddr_m[19:0] : xaddr_q;
          `EBW_REG_XWDATA: xwdata_q <= idle ? xwdata_m[15:0] : xwdata_q;
          `EBW_REG_CMD: begin
            if (idle && wb_sel_i[0]) begin
              cmd_write_q <= wb_dat_i[`EBW_BIT_CMD_WRITE];
              cmd_word_q <= wb_dat_i[`EBW_BIT_CMD_WORD];
              cmd_space_q <= wb_dat_i[`EBW_BIT_CMD_SPACE +: 2];
              split_q <= wb_dat_i[`EBW_BIT_CMD_WORD] &
                (is_narrow(wb_dat_i[`EBW_BIT_CMD_SPACE +: 2], aux_q) | xaddr_q[0]);
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule

//--- tb/ebw_bus_props.sv
// Checker for write enables, write strobe and address timing
`timescale 1ns/1ps
module ebw_bus_props (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Watched pins
  input wire hold_ack,
  input wire [19:0] nonmux_address,
  input wire [15:0] ad_out,
  input wire [15:0] ad_oe_n,
  input wire [7:0] upper_address_only_lines,
  input wire upper_address_only_oe_n,
  input wire upper_memory_select_n,
  input wire bus_high_enable_n,
  input wire write_high_byte_n,
  input wire write_high_byte_oe_n,
  input wire write_low_byte_n,
  input wire write_low_byte_oe_n,
  input wire write_byte_n,
  input wire write_byte_oe_n,
  input wire write_strobe_n,
  input wire write_strobe_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Strobe low for steps 3 to 6 with the address standing still
  sequence strobe_held;
    (!write_strobe_n && $stable(nonmux_address)) [*4] ##1 write_strobe_n;
  endsequence
  a_high_or: assert property (
    !write_high_byte_oe_n |-> write_high_byte_n == (bus_high_enable_n | write_strobe_n))
    else $error("high byte enable mismatch");
  a_low_strobe: assert property (
    !write_low_byte_oe_n && !write_low_byte_n |-> !write_strobe_n)
    else $error("low byte enable without strobe");
  a_bytes_float: assert property (
    disable iff (1'b0) rst |=> write_high_byte_oe_n && write_low_byte_oe_n)
    else $error("byte enables driven in reset");
  a_strobe_rst: assert property (
    disable iff (1'b0) rst |=> write_strobe_oe_n)
    else $error("strobe driven in reset");
  a_strobe_hold: assert property (
    hold_ack |-> write_strobe_oe_n)
    else $error("strobe driven in hold");
  a_addr_steady: assert property (
    $fell(write_strobe_n) |-> strobe_held)
    else $error("address moved during strobe");
  a_addr_early: assert property (
    $fell(write_strobe_n) |-> nonmux_address == $past(nonmux_address, 3))
    else $error("address not set at cycle start");
  a_bhe_aligned: assert property (
    $fell(write_strobe_n) |-> bus_high_enable_n == $past(bus_high_enable_n, 3))
    else $error("high enable not aligned with address");
  a_mux_addr: assert property (
    $fell(upper_memory_select_n) && ad_oe_n == 16'h0000
      |-> ad_out == nonmux_address[15:0] && $past(nonmux_address) == nonmux_address)
    else $error("shared bus address wrong");
  a_data_lanes: assert property (
    !write_strobe_n && !write_low_byte_n |-> ad_oe_n[7:0] == 8'h00)
    else $error("low lane not driven with data");
  a_byte_and: assert property (
    !write_byte_oe_n |-> write_byte_n == (write_high_byte_n & write_low_byte_n))
    else $error("write byte not the AND of both enables");
  a_byte_float: assert property (
    disable iff (1'b0) rst |=> write_byte_oe_n)
    else $error("write byte driven in reset");
  a_upper_lines: assert property (
    !write_byte_oe_n && !write_strobe_n
      |-> !upper_address_only_oe_n && upper_address_only_lines == nonmux_address[15:8])
    else $error("upper address lines not driven in data");
  a_narrow_lane: assert property (
    !write_byte_oe_n && !write_strobe_n |-> ad_oe_n == 16'hff00)
    else $error("narrow variant drove the high lane");
endmodule

bind ebw_bus_unit ebw_bus_props ebw_bus_props_inst (
  .clk(clk), .rst(rst), .hold_ack(hold_ack), .nonmux_address(nonmux_address),
  .ad_out(ad_out), .ad_oe_n(ad_oe_n), .upper_memory_select_n(upper_memory_select_n),
  .bus_high_enable_n(bus_high_enable_n), .write_high_byte_n(write_high_byte_n),
  .write_high_byte_oe_n(write_high_byte_oe_n), .write_low_byte_n(write_low_byte_n),
  .write_low_byte_oe_n(write_low_byte_oe_n), .write_strobe_n(write_strobe_n),
  .write_strobe_oe_n(write_strobe_oe_n), .write_byte_n(write_byte_n),
  .write_byte_oe_n(write_byte_oe_n), .upper_address_only_lines(upper_address_only_lines),
  .upper_address_only_oe_n(upper_address_only_oe_n));

//--- tb/ebw_ext_mem.sv
// Behavioural external memory on the shared address/data bus
`timescale 1ns/1ps
module ebw_ext_mem (
  // Clock
  input wire clk,
  // Address and data
  input wire [19:0] nonmux_address,
  input wire nonmux_address_oe_n,
  input wire [15:0] ad_out,
  input wire [15:0] ad_oe_n,
  output logic [15:0] ad_in,
  // Selects and write enables
  input wire upper_memory_select_n,
  input wire lower_memory_select_n,
  input wire write_high_byte_n,
  input wire write_low_byte_n,
  input wire write_strobe_n
);
  logic [7:0] mem [0:63];
  logic [15:0] addr_val = 16'h0000;
  logic strobe_q = 1'b1;
  logic sel_q = 1'b1;
  logic addr_drv = 1'b0;
  int wr_count = 0;
  wire sel_n = upper_memory_select_n & lower_memory_select_n;
  wire [5:0] ix = nonmux_address[5:0];
  initial ad_in = 16'h0000;
  always @(posedge clk) begin
    strobe_q <= write_strobe_n;
    sel_q <= sel_n;
    if (!write_strobe_n && strobe_q)
      wr_count <= wr_count + 1;
    // An 8-bit device sits on the low lane and sees the true address
    if (!write_strobe_n && !write_high_byte_n)
      mem[ix | 6'h01] <= ad_out[15:8];
    if (!write_strobe_n && !write_low_byte_n)
      mem[ix] <= ad_out[7:0];
    if (!sel_n && sel_q) begin
      addr_drv <= ad_oe_n != 16'hffff;
      addr_val <= ad_out;
    end
    // Released bus shows the inverse, so a stale copy never passes
    ad_in <= nonmux_address_oe_n ? ~ad_in : {mem[ix | 6'h01], mem[ix]};
  end
endmodule

//--- tb/ebw_bus_unit_tb.sv
// Self-checking bench for the external bus unit
`timescale 1ns/1ps
module ebw_bus_unit_tb;
  typedef struct packed {
    logic [2:0] aux;
    logic [1:0] sp;
    logic wd;
    logic [19:0] a;
    logic [15:0] d;
  } ebw_row_t;
  logic clk, rst, cyc, stb, we, hreq, strap;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, q;
  wire [31:0] rdat;
  wire ack, hack, na_oe_n, usel_n, lsel_n, whb_n, wlb_n, ws_n;
  wire whb_oe_n, wlb_oe_n, ws_oe_n, s6_oe_n, uzi_oe_n;
  wire [19:0] na;
  wire [15:0] ad_o, ad_oe_n, ad_i;
  int errors, checked, n, k;
  ebw_row_t rows [8];

  ebw_bus_unit #(.NARROW(0)) ebw_bus_unit_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .hold_request(hreq), .hold_ack(hack), .address_enable_strap(strap),
    .processor_clock_out(), .nonmux_address(na), .nonmux_address_oe_n(na_oe_n),
    .ad_out(ad_o), .ad_oe_n(ad_oe_n), .ad_in(ad_i), .upper_address_only_lines(),
    .upper_address_only_oe_n(), .upper_memory_select_n(usel_n),
    .lower_memory_select_n(lsel_n), .bus_high_enable_n(), .cycle_status_6(),
    .cycle_status_6_oe_n(s6_oe_n), .upper_zero_indicate(),
    .upper_zero_indicate_oe_n(uzi_oe_n), .write_high_byte_n(whb_n),
    .write_high_byte_oe_n(whb_oe_n), .write_low_byte_n(wlb_n),
    .write_low_byte_oe_n(wlb_oe_n), .write_byte_n(), .write_byte_oe_n(),
    .write_strobe_n(ws_n), .write_strobe_oe_n(ws_oe_n));

  // Narrow variant follows the same register traffic; the bound checker judges its pins
  ebw_bus_unit #(.NARROW(1)) ebw_bus_unit_8_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(), .hold_request(hreq),
    .hold_ack(), .address_enable_strap(strap), .processor_clock_out(), .nonmux_address(),
    .nonmux_address_oe_n(), .ad_out(), .ad_oe_n(), .ad_in(ad_i),
    .upper_address_only_lines(), .upper_address_only_oe_n(), .upper_memory_select_n(),
    .lower_memory_select_n(), .bus_high_enable_n(), .cycle_status_6(),
    .cycle_status_6_oe_n(), .upper_zero_indicate(), .upper_zero_indicate_oe_n(),
    .write_high_byte_n(), .write_high_byte_oe_n(), .write_low_byte_n(),
    .write_low_byte_oe_n(), .write_byte_n(), .write_byte_oe_n(), .write_strobe_n(),
    .write_strobe_oe_n());

  ebw_ext_mem ebw_ext_mem_inst (
    .clk(clk), .nonmux_address(na), .nonmux_address_oe_n(na_oe_n), .ad_out(ad_o),
    .ad_oe_n(ad_oe_n), .ad_in(ad_i), .upper_memory_select_n(usel_n),
    .lower_memory_select_n(lsel_n), .write_high_byte_n(whb_n),
    .write_low_byte_n(wlb_n), .write_strobe_n(ws_n));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; read data taken at the edge that sees ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t >= 50) errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task ext(input logic [1:0] sp, input logic w, input logic wd, input logic [19:0] a,
           input logic [15:0] d);
    int t;
    t = 0;
    wb(1'b1, 8'h0c, {12'h000, a});
    wb(1'b1, 8'h10, {16'h0000, d});
    wb(1'b1, 8'h14, {28'h0000000, sp, wd, w});
    q = 32'h1;
    while (q[0] !== 1'b0 && t < 60) begin
      wb(1'b0, 8'h14, 32'h0);
      t++;
    end
    if (t >= 60) errors++;
    wb(1'b0, 8'h18, 32'h0);
  endtask

  function automatic logic [31:0] beats(input ebw_row_t r);
    logic nar;
    nar = (r.sp == 2'h1 && r.aux[0]) || (r.sp == 2'h2 && r.aux[1]) || (r.sp == 2'h3 && r.aux[2]);
    return (r.wd && (nar || r.a[0])) ? 32'h2 : 32'h1;
  endfunction

  task wrap_up;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #800000;
    errors++;
    wrap_up;
  end

  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    hreq = 1'b0;
    strap = 1'b1;
    rows[0] = {3'h0, 2'h0, 1'b1, 20'h00010, 16'ha55a};
    rows[1] = {3'h0, 2'h1, 1'b0, 20'h00013, 16'h003c};
    rows[2] = {3'h1, 2'h1, 1'b1, 20'h00020, 16'h1234};
    rows[3] = {3'h2, 2'h2, 1'b1, 20'h00031, 16'hbeef};
    rows[4] = {3'h4, 2'h3, 1'b1, 20'h00004, 16'h7788};
    rows[5] = {3'h0, 2'h3, 1'b1, 20'h00007, 16'hcafe};
    rows[6] = {3'h7, 2'h0, 1'b1, 20'h00040, 16'h5aa5};
    rows[7] = {3'h0, 2'h2, 1'b1, 20'h0002a, 16'h0f0f};
    repeat (4) @(posedge clk);
    chk("float in reset", 32'h7, {29'h0, whb_oe_n, wlb_oe_n, ws_oe_n});
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h08, 32'h0);
    chk("width reset", 32'h0, q);
    for (k = 0; k < 8; k++) begin
      // Width only changes between accesses, never under one
      wb(1'b1, 8'h08, {29'h0, rows[k].aux});
      n = ebw_ext_mem_inst.wr_count;
      ext(rows[k].sp, 1'b1, rows[k].wd, rows[k].a, rows[k].d);
      chk("beats", beats(rows[k]), 32'(ebw_ext_mem_inst.wr_count - n));
      chk("low byte", {24'h0, rows[k].d[7:0]},
          {24'h0, ebw_ext_mem_inst.mem[rows[k].a[5:0]]});
      ext(rows[k].sp, 1'b0, rows[k].wd, rows[k].a, 16'h0000);
      if (rows[k].wd)
        chk("read word", {16'h0, rows[k].d}, {16'h0, q[15:0]});
      else
        chk("read byte", {24'h0, rows[k].d[7:0]}, {24'h0, q[7:0]});
    end
    wb(1'b1, 8'h08, 32'h0);
    ext(2'h0, 1'b1, 1'b0, 20'h0123c, 16'h0011);
    chk("address phase", 32'h1123c,
        {15'h0, ebw_ext_mem_inst.addr_drv, ebw_ext_mem_inst.addr_val});
    wb(1'b1, 8'h00, 32'h1);
    ext(2'h0, 1'b1, 1'b0, 20'h0123c, 16'h0022);
    chk("address disabled", 32'h0, {31'h0, ebw_ext_mem_inst.addr_drv});
    wb(1'b0, 8'h14, 32'h0);
    chk("strap high", 32'h0, {31'h0, q[1]});
    chk("status pins as pio", 32'h1, {31'h0, s6_oe_n});
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    hreq <= 1'b1;
    n = 0;
    while (hack !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk("strobe in hold", 32'h1, {31'h0, ws_oe_n});
    hreq <= 1'b0;
    repeat (4) @(posedge clk);
    // Second reset with the strap low selects classic multiplexed mode
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h14, 32'h0);
    chk("strap low", 32'h1, {31'h0, q[1]});
    chk("status pins normal", 32'h0, {30'h0, s6_oe_n, uzi_oe_n});
    wb(1'b1, 8'h00, 32'h1);
    ext(2'h0, 1'b1, 1'b1, 20'h00016, 16'h3344);
    chk("disable ignored", 32'h10016,
        {15'h0, ebw_ext_mem_inst.addr_drv, ebw_ext_mem_inst.addr_val});
    wrap_up;
  end
endmodule
